// File: src/ebm_master.sv
// expansion-bus master: one byte-wide-peripheral access per command,
// both strobe styles, arbitration, timed phases and bus clock output
// assumes a host port on CLK; all bus pins are asynchronous to CLK
// Summary of operation
// - style field picks strobe pair or rd/wr
// - rd/wr style: latch enable low whole cycle
// - rd/wr style: read strobe pulses, high on writes
// - rd/wr style: write strobe pulses, high on reads
// - rd/wr style: hold request high to own bus
// - strobe pair: address strobe low whole cycle
// - strobe pair: data strobe pulses for both directions
// - direction high for reads, low for writes
// - strobe pair: bus request low to own bus
// - take grant ack when free, release after
// - float lines idle, drive after acknowledge
// - drop hold at end, float after acknowledge falls
// - grant low and ack free: take ack, drive
// - drop request early, release ack, then float
// - muxed: single byte transfers only
// - address held one plus duration bus clocks
// - data held one plus duration bus clocks
// - gap of one plus interval before next request
// - bus clock halved when fast host clock
`timescale 1ns/10ps
`include "ebm_regs.svh"
module ebm_master
   import ebm_pkg::*;
(
   input  wire logic            CLK,
   input  wire logic            RST_N,
   input  wire logic [4:0]      REG_ADDR,
   input  wire logic [31:0]     REG_WDATA,
   input  wire logic            REG_WR,
   input  wire logic            REG_RD,
   output logic [31:0]          REG_RDATA,
   input  wire ebm_pin_in_type  EXP_IN,
   output ebm_pin_out_type      EXP_OUT
);
   // true on a bus clock tick once the phase counter has reached the limit
   function automatic logic last_cnt(input logic t, input logic [2:0] c,
                                     input logic [2:0] lim);
      last_cnt = t && (c == lim);
   endfunction

   // at most one byte enabled (low active enables)
   function automatic logic one_byte(input logic [3:0] be_n);
      logic [3:0] be;
      be = ~be_n;
      one_byte = ((be & (be - 4'h1)) == 4'h0);
   endfunction

   // two-stage synchroniser for every bus pin
   ebm_pin_in_type in_m;     // first stage, read only by in_s
   ebm_pin_in_type in_s;     // synchronised pins

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         in_m <= '0;
         in_s <= '0;
      end else begin
         in_m <= EXP_IN;
         in_s <= in_m;
      end
   end

   // software registers
   logic [`EBM_CFG_W-1:0] cfg;         // configuration
   logic [21:0]           adr;         // address and byte enables
   logic [31:0]           wdat;        // write data
   logic [31:0]           rdat;        // captured read data
   logic                  go;          // command pending
   logic                  is_wr;       // pending command is a write
   logic                  done;        // sticky, read data ready
   logic                  err;         // sticky, refused command
   logic [31:0]           next_rdata;
   logic [`EBM_CFG_W-1:0] next_cfg;
   logic [21:0]           next_adr;
   logic [31:0]           next_wdat;
   logic                  next_go;
   logic                  next_is_wr;
   logic                  next_done;
   logic                  next_err;

   // fsm state
   ebm_state_type         st;          // bus sequencer state
   logic                  sty;         // latched style, 1 = strobe pair
   logic [2:0]            cnt;         // bus clock counter in a phase
   logic                  div;         // bus clock divider flop
   logic [1:0]            rd_pipe;     // strobe-low history for capture
   ebm_pin_out_type       pins;        // registered bus pins
   ebm_state_type         next_st;
   logic                  next_sty;
   logic [2:0]            next_cnt;
   logic                  next_div;
   logic [1:0]            next_rd_pipe;
   ebm_pin_out_type       next_pins;
   logic                  tick;        // last host cycle of a bus clock
   logic                  fin;         // access finished this cycle
   logic                  cmd_wr;      // software writes the command
   logic                  refuse;      // command breaks muxed limit

   assign cmd_wr = REG_WR && (REG_ADDR == `EBM_OFS_CMD)
                   && REG_WDATA[`EBM_CMD_GO];
   // muxed wiring gives each peripheral its own lane, one per access
   assign refuse = cfg[`EBM_CFG_MUX] && !one_byte(adr[`EBM_ADR_BE]);
   // fast host clock: one bus clock every two host cycles
   assign tick   = !in_s.fast || div;
   assign fin    = (st == ST_GAP) && last_cnt(tick, cnt, cfg[`EBM_CFG_GAP]);

   // register next values; a busy engine ignores new commands
   always_comb begin
      next_cfg   = cfg;
      next_adr   = adr;
      next_wdat  = wdat;
      next_go    = go;
      next_is_wr = is_wr;
      next_done  = done;
      next_err   = err;
      next_rdata = 32'h0;
      if (REG_WR) begin
         unique case (REG_ADDR)
            `EBM_OFS_CFG:  next_cfg  = REG_WDATA[`EBM_CFG_W-1:0];
            `EBM_OFS_ADR:  next_adr  = REG_WDATA[21:0];
            `EBM_OFS_WDAT: next_wdat = REG_WDATA;
            `EBM_OFS_STAT: begin
               // write one to clear; a same-cycle set below wins
               if (REG_WDATA[`EBM_ST_DONE]) next_done = 1'b0;
               if (REG_WDATA[`EBM_ST_ERR])  next_err  = 1'b0;
            end
            default: ;
         endcase
      end
      if (cmd_wr && !go) begin
         if (refuse) begin
            next_err = 1'b1;
         end else begin
            next_go    = 1'b1;
            next_is_wr = REG_WDATA[`EBM_CMD_WRITE];
            next_done  = 1'b0;
         end
      end
      if (fin) begin
         next_go   = 1'b0;
         next_done = !is_wr;
      end
      if (REG_RD) begin
         unique case (REG_ADDR)
            `EBM_OFS_CFG:  next_rdata = {22'h0, cfg};
            `EBM_OFS_ADR:  next_rdata = {10'h0, adr};
            `EBM_OFS_WDAT: next_rdata = wdat;
            `EBM_OFS_STAT: next_rdata = {29'h0, err, done, go};
            `EBM_OFS_RDAT: next_rdata = rdat;
            default:       next_rdata = 32'h0;     // unmapped reads zero
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cfg       <= `EBM_CFG_RST;
         adr       <= `EBM_ADR_RST;
         wdat      <= 32'h0;
         go        <= 1'b0;
         is_wr     <= 1'b0;
         done      <= 1'b0;
         err       <= 1'b0;
         REG_RDATA <= 32'h0;
      end else begin
         cfg       <= next_cfg;
         adr       <= next_adr;
         wdat      <= next_wdat;
         go        <= next_go;
         is_wr     <= next_is_wr;
         done      <= next_done;
         err       <= next_err;
         REG_RDATA <= next_rdata;
      end
   end

   // read data capture: synchroniser lags two cycles, so the value
   // latched is the last one seen while the strobe was low
   logic [31:0] next_rdat;
   always_comb begin
      next_rd_pipe = {rd_pipe[0], (st == ST_DATA) && !is_wr};
      next_rdat    = rdat;
      if (rd_pipe[1]) next_rdat = in_s.ad;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rd_pipe <= 2'b00;
         rdat    <= 32'h0;
      end else begin
         rd_pipe <= next_rd_pipe;
         rdat    <= next_rdat;
      end
   end

   // bus sequencer: arbitration, address, data, release, gap
   always_comb begin
      next_st   = st;
      next_sty  = sty;
      next_cnt  = cnt;
      next_pins = pins;
      next_div  = in_s.fast ? !div : 1'b0;
      // full-rate mode cannot come from a flop, pin toggles each host cycle; in fast mode it shows the tick
      next_pins.clk = in_s.fast ? !div : !pins.clk;
      unique case (st)
         ST_IDLE: begin
            // everything floats, request inactive for current style
            next_pins.ad_oe   = 1'b0;
            next_pins.ctl_oe  = 1'b0;
            next_pins.gack_oe = 1'b0;
            next_pins.req     = cfg[`EBM_CFG_STYLE];
            if (go) begin
               next_sty      = cfg[`EBM_CFG_STYLE];
               next_pins.req = !cfg[`EBM_CFG_STYLE];
               next_st       = ST_REQ;
            end
         end
         ST_REQ: begin
            if (!sty) begin
               if (in_s.own_ack) next_st = ST_PRE_A;
            end else if (!in_s.grant_n && in_s.gack_n) begin
               next_pins.gack_n  = 1'b0;
               next_pins.gack_oe = 1'b1;
               next_st           = ST_PRE_A;
            end
         end
         ST_PRE_A: begin
            // drive address, byte enables and idle strobes
            next_pins.ad      = {`EBM_ADDR_PAD, adr[`EBM_ADR_ADDR]};
            next_pins.be_n    = adr[`EBM_ADR_BE];
            next_pins.ad_oe   = 1'b1;
            next_pins.ctl_oe  = 1'b1;
            next_pins.astb_n  = 1'b0;
            next_pins.rd_ds_n = 1'b1;
            next_pins.wr_dir  = sty ? !is_wr : 1'b1;
            if (sty) next_pins.req = 1'b1;
            next_cnt = `EBM_CNT_ZERO;
            next_st  = ST_ADDR;
         end
         ST_ADDR: begin
            if (last_cnt(tick, cnt, {1'b0, cfg[`EBM_CFG_ADUR]})) begin
               next_st = ST_PST_A;
            end else if (tick) begin
               next_cnt = cnt + `EBM_CNT_ONE;
            end
         end
         ST_PST_A: begin
            // turn the lines round: data for writes, float for reads
            next_pins.ad    = wdat;
            next_pins.ad_oe = is_wr;
            next_st         = ST_PRE_D;
         end
         ST_PRE_D: begin
            if (sty) next_pins.rd_ds_n = 1'b0;
            else if (is_wr) next_pins.wr_dir = 1'b0;
            else next_pins.rd_ds_n = 1'b0;
            next_cnt = `EBM_CNT_ZERO;
            next_st  = ST_DATA;
         end
         ST_DATA: begin
            if (last_cnt(tick, cnt, cfg[`EBM_CFG_DDUR])) begin
               next_pins.rd_ds_n = 1'b1;
               next_pins.wr_dir  = sty ? !is_wr : 1'b1;
               next_cnt          = `EBM_CNT_ZERO;
               next_st           = ST_PST_D;
            end else if (tick) begin
               next_cnt = cnt + `EBM_CNT_ONE;
            end
         end
         ST_PST_D: begin
            if (tick) begin
               next_pins.astb_n = 1'b1;
               if (sty) next_pins.gack_n = 1'b1;
               else next_pins.req = 1'b0;
               next_st = ST_REL;
            end
         end
         ST_REL: begin
            // rd/wr style waits for acknowledge to fall first
            if (sty || !in_s.own_ack) begin
               next_pins.ad_oe   = 1'b0;
               next_pins.ctl_oe  = 1'b0;
               next_pins.gack_oe = 1'b0;
               next_cnt          = `EBM_CNT_ZERO;
               next_st           = ST_GAP;
            end
         end
         ST_GAP: begin
            // guards against a stale grant being taken as a new one
            if (fin) next_st = ST_IDLE;
            else if (tick) next_cnt = cnt + `EBM_CNT_ONE;
         end
         default: next_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         st           <= ST_IDLE;
         sty          <= 1'b0;
         cnt          <= `EBM_CNT_ZERO;
         div          <= 1'b0;
         pins         <= '0;
         pins.be_n    <= 4'hf;
         pins.astb_n  <= 1'b1;
         pins.rd_ds_n <= 1'b1;
         pins.wr_dir  <= 1'b1;
         pins.gack_n  <= 1'b1;
      end else begin
         st   <= next_st;
         sty  <= next_sty;
         cnt  <= next_cnt;
         div  <= next_div;
         pins <= next_pins;
      end
   end

   assign EXP_OUT = pins;
endmodule // ebm_master

// File: src/ebm_pkg.sv
// types shared by the expansion-bus master and its bench
package ebm_pkg;
   // pins driven toward the expansion bus
   typedef struct packed {
      logic [31:0] ad;       // exp_addr_data out
      logic        ad_oe;    // address/data enable
      logic [3:0]  be_n;     // exp_byte_enable, low active
      logic        ctl_oe;   // enable of be, strobes, direction
      logic        astb_n;   // latch enable / addr_valid_strobe_n
      logic        rd_ds_n;  // read strobe / transfer_strobe_n
      logic        wr_dir;   // write strobe low / direction high=read
      logic        req;      // hold request high / bus_request_n low
      logic        gack_n;   // grant_acknowledge_n out
      logic        gack_oe;  // grant_acknowledge_n enable
      logic        clk;      // exp_bus_clock
   } ebm_pin_out_type;
   // pins sampled from the expansion bus
   typedef struct packed {
      logic [31:0] ad;       // exp_addr_data in
      logic        own_ack;  // own_acknowledge_hi
      logic        grant_n;  // bus_grant_n
      logic        gack_n;   // grant_acknowledge_n in
      logic        fast;     // fast_host_clock_in
   } ebm_pin_in_type;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_REQ   = 4'b0001,
      ST_PRE_A = 4'b0010,
      ST_ADDR  = 4'b0011,
      ST_PST_A = 4'b0100,
      ST_PRE_D = 4'b0101,
      ST_DATA  = 4'b0110,
      ST_PST_D = 4'b0111,
      ST_REL   = 4'b1000,
      ST_GAP   = 4'b1001
   } ebm_state_type;
endpackage

// File: src/ebm_regs.svh
// register offsets, field positions, reset values and counter constants
// for the expansion-bus master; definitions only
`ifndef EBM_REGS_SVH
`define EBM_REGS_SVH
`define EBM_OFS_CFG      5'h00
`define EBM_OFS_ADR      5'h04
`define EBM_OFS_WDAT     5'h08
`define EBM_OFS_CMD      5'h0c
`define EBM_OFS_STAT     5'h10
`define EBM_OFS_RDAT     5'h14
`define EBM_CFG_STYLE    0
`define EBM_CFG_ADUR     2:1
`define EBM_CFG_DDUR     5:3
`define EBM_CFG_GAP      8:6
`define EBM_CFG_MUX      9
`define EBM_CFG_W        10
`define EBM_CFG_RST      10'h000
`define EBM_ADR_ADDR     17:0
`define EBM_ADR_BE       21:18
`define EBM_ADR_RST      22'h3c0000
`define EBM_CMD_GO       0
`define EBM_CMD_WRITE    1
`define EBM_ST_BUSY      0
`define EBM_ST_DONE      1
`define EBM_ST_ERR       2
`define EBM_ADDR_PAD     14'h0000
`define EBM_CNT_ZERO     3'h0
`define EBM_CNT_ONE      3'h1
`endif

// File: tb/ebm_checker.sv
// pin-level checks of the expansion-bus master, bound to its top
// assumes cfg is rewritten only while the engine is idle
`timescale 1ns/10ps
`include "ebm_regs.svh"
module ebm_checker
   import ebm_pkg::*;
(
   input wire logic            CLK,
   input wire logic            RST_N,
   input wire logic [4:0]      REG_ADDR,
   input wire logic [31:0]     REG_WDATA,
   input wire logic            REG_WR,
   input wire logic            REG_RD,
   input wire logic [31:0]     REG_RDATA,
   input wire ebm_pin_in_type  EXP_IN,
   input wire ebm_pin_out_type EXP_OUT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   logic [9:0] cfg, next_cfg; // shadow of style and timing fields
   logic [4:0] low, next_low; // cycles the data strobe is low
   logic [5:0] gap, next_gap; // idle cycles since the bus floated
   logic [4:0] t;             // host cycles per bus clock
   logic       stb;           // data strobe active in either style
   logic [5:0] pre, next_pre; // address-phase cycles before the strobe
   // helper next values
   always_comb begin
      t = EXP_IN.fast ? 5'h2 : 5'h1;
      next_cfg = (REG_WR && REG_ADDR == `EBM_OFS_CFG) ? REG_WDATA[9:0] : cfg;
      // rd/wr writes strobe on the write line, everything else on rd_ds_n
      stb = EXP_OUT.ctl_oe && (!EXP_OUT.rd_ds_n || (!cfg[0] && !EXP_OUT.wr_dir));
      next_low = stb ? low + 5'h1 : 5'h0;
      next_pre = EXP_OUT.astb_n ? 6'h0 : pre + {5'h0, !stb};
      next_gap = EXP_OUT.ctl_oe ? 6'h0 : gap + {5'h0, gap != 6'h3f};
   end
   // gap starts saturated so the first request is never flagged
   always_ff @(posedge CLK) begin
      cfg <= RST_N ? next_cfg : `EBM_CFG_RST;
      low <= RST_N ? next_low : 5'h0;
      pre <= RST_N ? next_pre : 6'h0;
      gap <= RST_N ? next_gap : 6'h3f;
   end
   sequence s_strobe_end;
      $fell(stb);
   endsequence
   sequence s_strobe_start;
      $rose(stb);
   endsequence
   // address stands (1+A) bus clocks plus turn-round and pre-data cycles;
   // at half rate the first bus clock may be cut by one host cycle
   a_addr_width: assert property (s_strobe_start |->
      pre <= {1'b0, (5'h1 + {3'h0, cfg[2:1]}) * t} + 6'h2
      && pre + {1'b0, t} >= {1'b0, (5'h1 + {3'h0, cfg[2:1]}) * t} + 6'h3)
      else $error("address phase length wrong");
   a_strobe_width: assert property (s_strobe_end |->
      low == (5'h1 + {2'h0, cfg[5:3]}) * t) else $error("data strobe width wrong");
   a_gap_before_req: assert property ((cfg[0] ? $fell(EXP_OUT.req) : $rose(EXP_OUT.req)) |->
      gap >= {1'b0, (5'h1 + {2'h0, cfg[8:6]}) * t}) else $error("request too soon");
   a_latch_whole: assert property (EXP_OUT.ctl_oe && !EXP_OUT.rd_ds_n |-> !EXP_OUT.astb_n)
      else $error("strobe outside address cycle");
   a_one_strobe: assert property (EXP_OUT.ctl_oe && !cfg[0] |-> EXP_OUT.rd_ds_n || EXP_OUT.wr_dir)
      else $error("read and write strobe together");
   a_dir_steady: assert property (cfg[0] && !EXP_OUT.rd_ds_n && !$past(EXP_OUT.rd_ds_n) |->
      $stable(EXP_OUT.wr_dir)) else $error("direction moved under strobe");
   a_drive_on_hold: assert property ($rose(EXP_OUT.ctl_oe) && !cfg[0] |-> EXP_OUT.req)
      else $error("bus driven without hold request");
   a_req_freed: assert property (cfg[0] && EXP_OUT.ctl_oe && !EXP_OUT.rd_ds_n |-> EXP_OUT.req)
      else $error("bus request kept into data phase");
   a_ack_taken: assert property ($rose(EXP_OUT.gack_oe) |-> !EXP_OUT.gack_n && !EXP_IN.grant_n)
      else $error("grant ack taken without grant");
   a_ack_released: assert property ($fell(EXP_OUT.gack_oe) |-> $past(EXP_OUT.gack_n))
      else $error("grant ack floated while low");
   a_hold_dropped: assert property (!cfg[0] && $fell(EXP_OUT.ctl_oe) |->
      !EXP_OUT.req && !EXP_IN.own_ack) else $error("bus floated before acknowledge fell");
   a_clk_full: assert property (!EXP_IN.fast && $past(RST_N, 2) |->
      EXP_OUT.clk != $past(EXP_OUT.clk)) else $error("bus clock not toggling");
endmodule // ebm_checker
bind ebm_master ebm_checker u_chk (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .EXP_IN(EXP_IN), .EXP_OUT(EXP_OUT));

// File: tb/ebm_far_side.sv
// far side of the expansion bus: one arbiter and byte-wide peripherals
// assumes the bench tells it the strobe style in use
`timescale 1ns/10ps
module ebm_far_side
   import ebm_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            style,   // 1 = strobe pair
   input  wire logic [2:0]      dly,     // arbiter answer delay
   input  wire ebm_pin_out_type pins,
   output logic [31:0]          ad,      // resolved data wire
   output logic                 ack,
   output logic                 grant_n,
   output logic                 gack_n,  // wire with pull-up
   output logic [7:0]           wr_cnt,
   output logic [7:0]           rd_cnt,
   output logic [31:0]          w_dat,
   output logic [17:0]          adr,
   output logic [3:0]           be
);
   logic        own, want;      // bus handed over / asked for
   logic [2:0]  cnt;            // answer delay count
   logic        as_q, ws, rs, ws_q, rs_q, rdrv;
   logic [31:0] ad_q;           // last wire value
   // wire resolution and arbiter outputs
   always_comb begin
      want = style ? !pins.req : pins.req;
      ack = !style && own;
      grant_n = !(style && own);
      gack_n = pins.gack_oe ? pins.gack_n : 1'b1;
      ws = pins.ctl_oe && !pins.wr_dir && (!style || !pins.rd_ds_n);
      rs = pins.ctl_oe && !pins.rd_ds_n && (!style || pins.wr_dir);
      rdrv = pins.ctl_oe && !pins.ad_oe && !pins.astb_n;
      // released wire shows a pattern that changes every cycle
      ad = pins.ad_oe ? pins.ad : ~ad_q;
      if (!pins.ad_oe && rdrv)
         ad = {adr[7:0] ^ 8'h3c, adr[15:8], 8'ha5, adr[7:0]};
   end
   // answer only after the delay, so the grant outlives the request
   always_ff @(posedge clk) begin
      ad_q <= ad;
      as_q <= pins.astb_n;
      ws_q <= ws;
      rs_q <= rs;
      if (!rst_n) begin
         own <= 1'b0;
         cnt <= 3'h0;
         wr_cnt <= 8'h0;
         rd_cnt <= 8'h0;
      end else begin
         cnt <= (want != own && cnt < dly) ? cnt + 3'h1 : 3'h0;
         if (want != own && cnt >= dly)
            own <= want;
         if (!pins.astb_n && as_q)
            {be, adr} <= {pins.be_n, pins.ad[17:0]};
         if (ws)
            w_dat <= pins.ad;
         if (ws_q && !ws)
            wr_cnt <= wr_cnt + 8'h1;
         if (rs_q && !rs)
            rd_cnt <= rd_cnt + 8'h1;
      end
   end
endmodule // ebm_far_side

// File: tb/tb_ebm_master.sv
// self-checking bench of the expansion-bus master with a far-side model
// assumes the pin checker is bound in from its own file
`timescale 1ns/10ps
`include "ebm_regs.svh"
module tb_ebm_master
   import ebm_pkg::*;
   ;
   logic [4:0]      REG_ADDR;
   logic [31:0]     REG_WDATA, REG_RDATA, p_ad, w_dat;
   logic            CLK, RST_N, REG_WR, REG_RD, style, fast, p_ack, p_gnt_n, p_gack_n;
   logic [2:0]      dly;
   logic [7:0]      wr_cnt, rd_cnt, w0;
   logic [17:0]     p_adr;
   logic [3:0]      p_be;
   ebm_pin_in_type  EXP_IN;
   ebm_pin_out_type EXP_OUT;
   int              num_errors, checked;
   integer          seed;
   assign EXP_IN = '{ad: p_ad, own_ack: p_ack, grant_n: p_gnt_n, gack_n: p_gack_n, fast: fast};
   ebm_master uut (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EXP_IN(EXP_IN), .EXP_OUT(EXP_OUT));
   ebm_far_side far (.clk(CLK), .rst_n(RST_N), .style(style), .dly(dly), .pins(EXP_OUT),
      .ad(p_ad), .ack(p_ack), .grant_n(p_gnt_n), .gack_n(p_gack_n), .wr_cnt(wr_cnt),
      .rd_cnt(rd_cnt), .w_dat(w_dat), .adr(p_adr), .be(p_be));
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   task automatic end_of_test();
      if (num_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1 d = REG_RDATA;
   endtask
   // settle time lets a stale grant from the old style die away
   task automatic cfg_set(input logic [9:0] c);
      wr(`EBM_OFS_CFG, {22'h0, c});
      style <= c[0];
      repeat (12) @(posedge CLK);
   endtask
   task automatic acc(input logic w, input logic [17:0] a, input logic [3:0] b,
                      input logic [31:0] d);
      logic [31:0] s;
      logic [7:0]  wc, rc;
      int          n;
      wc = wr_cnt;
      rc = rd_cnt;
      wr(`EBM_OFS_ADR, {10'h0, b, a});
      wr(`EBM_OFS_WDAT, d);
      wr(`EBM_OFS_CMD, {30'h0, w, 1'b1});
      // a second command while busy must be ignored; counts below catch it
      wr(`EBM_OFS_CMD, {30'h0, !w, 1'b1});
      s = 32'h1;
      for (n = 0; n < 300 && s[0] !== 1'b0; n++)
         rd(`EBM_OFS_STAT, s);
      if (n == 300) begin
         $display("[ERR] busy expected 0 seen 1");
         num_errors++;
         end_of_test();
      end
      chk("wr_count", {24'h0, wc + {7'h0, w}}, {24'h0, wr_cnt});
      chk("rd_count", {24'h0, rc + {7'h0, !w}}, {24'h0, rd_cnt});
      chk("bus_addr", {10'h0, b, a}, {10'h0, p_be, p_adr});
      if (w)
         chk("wr_data", d, w_dat);
      else begin
         chk("stat_done", 32'h2, s);
         rd(`EBM_OFS_RDAT, s);
         chk("rd_data", {a[7:0] ^ 8'h3c, a[15:8], 8'ha5, a[7:0]}, s);
      end
      wr(`EBM_OFS_STAT, 32'h6);
   endtask
   // two runs, full-rate then fast host clock, each from reset
   initial begin
      logic [31:0] s;
      logic [9:0]  c;
      num_errors = 0;
      checked = 0;
      seed = 32'h206848eb;
      {RST_N, REG_WR, REG_RD, style, fast, dly} = '0;
      REG_ADDR = 5'h0;
      REG_WDATA = 32'h0;
      for (int seg = 0; seg < 2; seg++) begin
         @(posedge CLK);
         RST_N <= 1'b0;
         fast <= seg[0];
         repeat (16) @(posedge CLK);
         RST_N <= 1'b1;
         rd(`EBM_OFS_ADR, s);
         chk("adr_reset", 32'h3c0000, s);
         rd(5'h1c, s);
         chk("unmapped", 32'h0, s);
         wr(`EBM_OFS_CFG, 32'hffffffff);
         rd(`EBM_OFS_CFG, s);
         chk("cfg_fields", 32'h3ff, s);
         for (int i = 0; i < 20; i++) begin
            c = (i == 0) ? 10'h1fe : (i == 1) ? 10'h001 : {1'b0, 9'($random(seed))};
            dly <= 3'($random(seed));
            cfg_set(c);
            acc(1'($random(seed)), 18'($random(seed)), 4'($random(seed)), $random(seed));
         end
         cfg_set(10'h200);
         w0 = wr_cnt + rd_cnt;
         wr(`EBM_OFS_ADR, {10'h0, 4'b0011, 18'h155});
         wr(`EBM_OFS_CMD, 32'h3);
         rd(`EBM_OFS_STAT, s);
         chk("mux_refused", 32'h4, s);
         chk("mux_no_cycle", {24'h0, w0}, {24'h0, wr_cnt + rd_cnt});
         wr(`EBM_OFS_STAT, 32'h6);
         acc(1'b0, 18'h2aaaa, 4'b1101, 32'h0);
      end
      end_of_test();
   end
endmodule // tb_ebm_master
